// ===== design/adhr_host.sv
`timescale 1ns/100ps
// Operation
// - strobes low start conversion; restarts ignored
// - busy low for whole conversion
// - old data while converting, new before busy
// - slow 8-bit: first read stalls on busy
// - low byte to host, nibble to latch
// - second read takes no wait states
// - ROM read starts conversion, returns previous byte
// - upper nibble read from separate latch address
// - optionally wait, then read fresh result
// - busy rising edge usable as interrupt
// - no converter read during conversion
// - slow mode with latches holds strobes low
// - busy rise clocks result into latches
// - latch clock delayed about 100 ns
// - ROM reads spaced by conversion time
// - later ROM read fresh and restarts
// - gate strobes with busy during conversion
// - result as one word or two bytes
// - first decision one to two clock periods
// - hold-to-decision not below settling time
module adhr_host
  import adhr_pkg::*;
#(
  parameter int LAT_DLY = LATCH_DLY_CYC,
  parameter int SETTLE  = SETTLE_CYC,
  parameter int CONV    = CONV_CYC,
  parameter int RD_CYC  = ROM_RD_CYC
) (
  input  wire logic                clk_sys,
  input  wire logic                reset,
  adhr_if.host                     bus,
  input  wire logic                req,
  input  wire logic                mode,
  input  wire logic                wide,
  input  wire logic                wait_fresh,
  output logic                     ack,
  output logic [RESULT_W-1:0]      rdata,
  output logic                     irq,
  output logic                     active
);
  generate
    if (LAT_DLY < 1 || SETTLE < 1 || CONV < 1 || RD_CYC < 1) begin : g_chk
      $error("host timing counts must be at least 1");
    end
  endgenerate

  typedef enum logic [2:0] {
    H_IDLE   = 3'b000,
    H_SETTLE = 3'b001,
    H_STALL  = 3'b010,
    H_ROMRD  = 3'b011,
    H_BYTE2  = 3'b100,
    H_FRESH  = 3'b101,
    H_DONE   = 3'b110
  } adhr_hstate_t;

  localparam int CW = $clog2(CONV + SETTLE + RD_CYC + 1);
  localparam int LW = $clog2(LAT_DLY + 1);

  adhr_hstate_t        state_ff;
  logic [CW-1:0]       cnt_ff;
  logic [CW-1:0]       gap_ff;
  logic [LW-1:0]       ldly_ff;
  logic [BYTE_W-1:0]   lo_ff;
  logic [RESULT_W-1:0] ext_ff;
  logic [RESULT_W-1:0] rdata_ff;
  adhr_mode_t          mode_ff;
  logic                wide_ff;
  logic                fresh_ff;
  logic                strobe_ff;
  logic                hold_ff;
  logic                busy_q_ff;
  logic                saw_busy_ff;
  logic                lat_load_ff;
  logic                lat_seen_ff;
  logic                ack_ff;
  logic                irq_ff;
  logic                active_ff;
  logic                busy_rise;
  logic                rom_ok;

  assign busy_rise = bus.busy_n & ~busy_q_ff;
  // no ROM read while converting or before a conversion time has passed
  assign rom_ok    = bus.busy_n & (gap_ff == '0);

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      busy_q_ff <= 1'b1;
    end else begin
      busy_q_ff <= bus.busy_n;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= busy_rise;
    end
  end

  // external latch clock: busy rise delayed so data has settled first
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ldly_ff     <= '0;
      lat_load_ff <= 1'b0;
      ext_ff      <= RESULT_RST;
    end else begin
      lat_load_ff <= 1'b0;
      if (busy_rise) begin
        ldly_ff <= LW'(LAT_DLY);
      end else if (ldly_ff != '0) begin
        ldly_ff <= ldly_ff - LW'(1);
        if (ldly_ff == LW'(1)) begin
          ext_ff      <= bus.result_bits;
          lat_load_ff <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      gap_ff <= '0;
    end else if (state_ff == H_ROMRD && cnt_ff == CW'(RD_CYC)) begin
      gap_ff <= CW'(CONV);
    end else if (gap_ff != '0) begin
      gap_ff <= gap_ff - CW'(1);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      saw_busy_ff <= 1'b0;
      lat_seen_ff <= 1'b0;
    end else if (state_ff == H_SETTLE) begin
      saw_busy_ff <= 1'b0;
      lat_seen_ff <= 1'b0;
    end else begin
      if (!bus.busy_n) begin
        saw_busy_ff <= 1'b1;
      end
      if (lat_load_ff && saw_busy_ff) begin
        lat_seen_ff <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_ff  <= H_IDLE;
      cnt_ff    <= '0;
      mode_ff   <= ADHR_SLOW;
      wide_ff   <= 1'b0;
      fresh_ff  <= 1'b0;
      strobe_ff <= 1'b0;
      hold_ff   <= 1'b0;
      lo_ff     <= '0;
      rdata_ff  <= RESULT_RST;
      ack_ff    <= 1'b0;
      active_ff <= 1'b0;
    end else begin
      ack_ff <= 1'b0;
      unique case (state_ff)
        H_IDLE: begin
          // neither mode may drop the strobes onto a running conversion
          if (req && bus.busy_n && (mode == ADHR_SLOW || rom_ok)) begin
            mode_ff   <= adhr_mode_t'(mode);
            wide_ff   <= wide;
            fresh_ff  <= wait_fresh;
            hold_ff   <= 1'b1;
            cnt_ff    <= CW'(SETTLE);
            active_ff <= 1'b1;
            state_ff  <= H_SETTLE;
          end
        end
        H_SETTLE: begin
          // hold leads the strobes by the settling time
          if (cnt_ff == CW'(1)) begin
            strobe_ff <= 1'b1;
            cnt_ff    <= '0;
            state_ff  <= (mode_ff == ADHR_SLOW) ? H_STALL : H_ROMRD;
          end else begin
            cnt_ff <= cnt_ff - CW'(1);
          end
        end
        H_STALL: begin
          // strobes stay low through the conversion, released after latch load
          if (lat_seen_ff) begin
            strobe_ff <= 1'b0;
            hold_ff   <= 1'b0;
            lo_ff     <= bus.result_bits[BYTE_W-1:0];
            if (wide_ff) begin
              rdata_ff <= bus.result_bits;
              state_ff <= H_DONE;
            end else begin
              state_ff <= H_BYTE2;
            end
          end
        end
        H_ROMRD: begin
          if (cnt_ff == CW'(RD_CYC)) begin
            strobe_ff <= 1'b0;
            hold_ff   <= 1'b0;
            lo_ff     <= bus.result_bits[BYTE_W-1:0];
            cnt_ff    <= '0;
            if (fresh_ff) begin
              fresh_ff <= 1'b0;
              state_ff <= H_FRESH;
            end else if (wide_ff) begin
              rdata_ff <= bus.result_bits;
              state_ff <= H_DONE;
            end else begin
              state_ff <= H_BYTE2;
            end
          end else begin
            cnt_ff <= cnt_ff + CW'(1);
          end
        end
        H_FRESH: begin
          // this read returns the fresh word and restarts the converter
          if (rom_ok) begin
            hold_ff  <= 1'b1;
            cnt_ff   <= CW'(SETTLE);
            state_ff <= H_SETTLE;
          end
        end
        H_BYTE2: begin
          // latch read: single cycle, never waits on busy
          rdata_ff <= {ext_ff[RESULT_W-1:BYTE_W], lo_ff};
          state_ff <= H_DONE;
        end
        H_DONE: begin
          ack_ff    <= 1'b1;
          active_ff <= 1'b0;
          state_ff  <= H_IDLE;
        end
        default: state_ff <= H_IDLE;
      endcase
    end
  end

  assign bus.cs_n = ~strobe_ff;
  assign bus.rd_n = ~strobe_ff;
  assign bus.hold = hold_ff;
  assign ack      = ack_ff;
  assign rdata    = rdata_ff;
  assign irq      = irq_ff;
  assign active   = active_ff;
endmodule : adhr_host

// ===== design/adhr_pkg.sv
package adhr_pkg;
  localparam int RESULT_W      = 12;
  localparam int BYTE_W        = 8;
  localparam int NIB_W         = RESULT_W - BYTE_W;
  localparam int CLK_NS        = 40;
  // conversion clock in system clocks per period
  localparam int CCLK_DIV_DEF  = 6;
  localparam int LATCH_DLY_NS  = 100;
  localparam int LATCH_DLY_CYC = (LATCH_DLY_NS + CLK_NS - 1) / CLK_NS;
  localparam int SETTLE_NS     = 200;
  localparam int SETTLE_CYC    = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int CONV_TIME_NS  = 4000;
  localparam int CONV_CYC      = (CONV_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int ROM_RD_CYC    = 2;
  localparam logic [RESULT_W-1:0] RESULT_RST = 12'h000;

  typedef enum logic {
    ADHR_SLOW = 1'b0,
    ADHR_ROM  = 1'b1
  } adhr_mode_t;
endpackage : adhr_pkg

// ===== design/adhr_if.sv
`timescale 1ns/100ps
interface adhr_if
  import adhr_pkg::*;
();
  logic                cs_n;
  logic                rd_n;
  logic                hold;
  logic                busy_n;
  logic [RESULT_W-1:0] result_bits;
  logic                result_oe;

  modport dev (
    input  cs_n,
    input  rd_n,
    input  hold,
    output busy_n,
    output result_bits,
    output result_oe
  );

  modport host (
    output cs_n,
    output rd_n,
    output hold,
    input  busy_n,
    input  result_bits,
    input  result_oe
  );
endinterface : adhr_if

// ===== design/adhr_dev.sv
`timescale 1ns/100ps
module adhr_dev
  import adhr_pkg::*;
#(
  parameter int CCLK_DIV = CCLK_DIV_DEF
) (
  input  wire logic                clk_sys,
  input  wire logic                reset,
  adhr_if.dev                      bus,
  input  wire logic [RESULT_W-1:0] analog_code,
  output logic                     first_dec
);
  generate
    if (CCLK_DIV < 2) begin : g_chk
      $error("CCLK_DIV must be at least 2");
    end
  endgenerate

  typedef enum logic [2:0] {
    D_IDLE = 3'b000,
    D_SYNC = 3'b001,
    D_CONV = 3'b010,
    D_LOAD = 3'b011,
    D_REL  = 3'b100
  } adhr_dstate_t;

  localparam int DW = $clog2(CCLK_DIV);
  localparam int BW = $clog2(RESULT_W);

  adhr_dstate_t        state_ff;
  logic [DW-1:0]       div_ff;
  logic [BW-1:0]       bit_ff;
  logic [RESULT_W-1:0] sar_ff;
  logic [RESULT_W-1:0] samp_ff;
  logic [RESULT_W-1:0] latch_ff;
  logic                strobe_ff;
  logic                busy_n_ff;
  logic                oe_ff;
  logic                first_ff;
  logic                tick;
  logic                strobe;
  logic                start;

  assign tick   = (div_ff == DW'(CCLK_DIV - 1));
  assign strobe = ~bus.cs_n & ~bus.rd_n;
  // later start requests are dropped until the running conversion ends
  assign start  = strobe & ~strobe_ff & (state_ff == D_IDLE);

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      div_ff <= '0;
    end else if (tick) begin
      div_ff <= '0;
    end else begin
      div_ff <= div_ff + DW'(1);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      strobe_ff <= 1'b0;
    end else begin
      strobe_ff <= strobe;
    end
  end

  // start aligns to the next conversion clock, first decision one period later
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_ff <= D_IDLE;
      bit_ff   <= '0;
      first_ff <= 1'b0;
    end else begin
      first_ff <= 1'b0;
      unique case (state_ff)
        D_IDLE: begin
          if (start) begin
            state_ff <= D_SYNC;
          end
        end
        D_SYNC: begin
          if (tick) begin
            state_ff <= D_CONV;
            bit_ff   <= BW'(RESULT_W - 1);
          end
        end
        D_CONV: begin
          if (tick) begin
            first_ff <= (bit_ff == BW'(RESULT_W - 1));
            if (bit_ff == '0) begin
              state_ff <= D_LOAD;
            end else begin
              bit_ff <= bit_ff - BW'(1);
            end
          end
        end
        D_LOAD: state_ff <= D_REL;
        D_REL:  state_ff <= D_IDLE;
        default: state_ff <= D_IDLE;
      endcase
    end
  end

  // input is frozen at the first decision, as the held sample would be
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      samp_ff <= RESULT_RST;
      sar_ff  <= RESULT_RST;
    end else if (state_ff == D_CONV && tick) begin
      if (bit_ff == BW'(RESULT_W - 1)) begin
        samp_ff <= analog_code;
        sar_ff  <= {analog_code[RESULT_W-1], {(RESULT_W - 1){1'b0}}};
      end else begin
        sar_ff[bit_ff] <= samp_ff[bit_ff];
      end
    end
  end

  // old result stays on the pins until the latch is loaded
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      latch_ff <= RESULT_RST;
    end else if (state_ff == D_LOAD) begin
      latch_ff <= sar_ff;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      busy_n_ff <= 1'b1;
    end else if (start) begin
      busy_n_ff <= 1'b0;
    end else if (state_ff == D_REL) begin
      busy_n_ff <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      oe_ff <= 1'b0;
    end else begin
      oe_ff <= strobe;
    end
  end

  // whole word is driven; byte split belongs to the host side
  assign bus.result_bits = latch_ff;
  assign bus.busy_n      = busy_n_ff;
  assign bus.result_oe   = oe_ff;
  assign first_dec       = first_ff;
endmodule : adhr_dev

// ===== tb/adhr_properties.sv
`timescale 1ns/100ps
module adhr_properties
  import adhr_pkg::*;
#(
  parameter int CCLK_DIV = CCLK_DIV_DEF
) (
  input wire logic                clk_sys,
  input wire logic                reset,
  input wire logic                cs_n,
  input wire logic                rd_n,
  input wire logic                hold,
  input wire logic                busy_n,
  input wire logic [RESULT_W-1:0] result_bits,
  input wire logic                result_oe
);
  // generous bound: up to two periods before the first decision plus twelve bits
  localparam int MAXC = 16 * CCLK_DIV + 8;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  sequence start_s;
    !cs_n && !rd_n && $past(cs_n || rd_n) && busy_n;
  endsequence
  sequence conv_s;
    !busy_n [*8];
  endsequence
  a_start_busy_low: assert property (start_s |=> conv_s)
    else $error("busy not low after start");
  a_busy_needs_strobe: assert property ($fell(busy_n) |-> $past(!cs_n && !rd_n))
    else $error("busy fell without strobes");
  a_busy_ends: assert property ($fell(busy_n) |-> ##[1:MAXC] busy_n)
    else $error("conversion never ended");
  a_new_before_busy: assert property ($changed(result_bits) |-> !busy_n ##1 busy_n)
    else $error("result changed outside conversion end");
  a_oe_follows_read: assert property (result_oe == $past(!cs_n && !rd_n))
    else $error("output enable not tied to read");
  a_strobes_paired: assert property (cs_n == rd_n)
    else $error("strobes not paired");
  a_hold_settled: assert property ($fell(cs_n) |-> hold && $past(hold, SETTLE_CYC))
    else $error("strobes before hold settled");
  a_hold_in_read: assert property (!cs_n |-> hold)
    else $error("hold dropped during read");
  a_no_busy_read: assert property ($fell(cs_n) |-> busy_n)
    else $error("read started during conversion");
endmodule : adhr_properties

// ===== tb/testbench.sv
`timescale 1ns/100ps
module testbench
  import adhr_pkg::*;
;
  localparam int DIV = 2;
  logic                clk_sys;
  logic                reset;
  logic                req;
  logic                mode;
  logic                wide;
  logic                wait_fresh;
  logic                ack;
  logic                irq;
  logic                active;
  logic                fd;
  logic                fd2;
  logic [RESULT_W-1:0] code;
  logic [RESULT_W-1:0] rdata;
  int                  failures;
  int                  total_checks;
  int                  irq_seen;
  int                  n1;
  int                  n2;
  int                  f1;
  int                  f2;
  adhr_if bus ();
  adhr_if bus2 ();
  adhr_dev #(.CCLK_DIV(DIV)) i_adhr_dev (.clk_sys(clk_sys), .reset(reset), .bus(bus),
    .analog_code(code), .first_dec(fd));
  // second device driven straight from the bench to misuse the strobes
  adhr_dev #(.CCLK_DIV(DIV)) i_adhr_dev_b (.clk_sys(clk_sys), .reset(reset), .bus(bus2),
    .analog_code(code), .first_dec(fd2));
  adhr_host #(.CONV(40)) i_adhr_host (.clk_sys(clk_sys), .reset(reset), .bus(bus), .req(req),
    .mode(mode), .wide(wide), .wait_fresh(wait_fresh), .ack(ack), .rdata(rdata), .irq(irq),
    .active(active));
  adhr_properties #(.CCLK_DIV(DIV)) i_adhr_properties (.clk_sys(clk_sys), .reset(reset),
    .cs_n(bus.cs_n), .rd_n(bus.rd_n), .hold(bus.hold), .busy_n(bus.busy_n),
    .result_bits(bus.result_bits), .result_oe(bus.result_oe));

  task automatic final_report();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : final_report

  task automatic chk_word(input string nm, input logic [RESULT_W-1:0] exp, input logic [RESULT_W-1:0] got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk_word

  task automatic chk_cnt(input string nm, input int exp, input int got);
    total_checks++;
    if (got != exp) begin
      failures++;
      $display("[ERR] %s expected %0d seen %0d", nm, exp, got);
    end
  endtask : chk_cnt

  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask : tick

  // req stays up until taken, since rom reads may wait for the gap counter
  task automatic xfer(input logic m, input logic w, input logic f, input logic [RESULT_W-1:0] a);
    int k;
    bit got;
    code = a;
    mode = m;
    wide = w;
    wait_fresh = f;
    req = 1'b1;
    irq_seen = 0;
    got = 1'b0;
    // edge first: the ack pulse of the previous call may still be standing here
    for (k = 0; k < 2000 && !got; k++) begin
      tick();
      if (active === 1'b1) req = 1'b0;
      if (irq === 1'b1) irq_seen++;
      if (ack === 1'b1) got = 1'b1;
    end
    if (!got) begin
      failures++;
      final_report();
    end
    for (k = 0; k < 200 && bus.busy_n !== 1'b1; k++) tick();
    if (bus.busy_n !== 1'b1) begin
      failures++;
      final_report();
    end
  endtask : xfer

  task automatic conv2(input bit glitch, output int n, output int f);
    int k;
    bus2.cs_n = 1'b0;
    bus2.rd_n = 1'b0;
    bus2.hold = 1'b1;
    n = 0;
    f = -1;
    for (k = 0; k < 200 && !(n > 0 && bus2.busy_n === 1'b1); k++) begin
      tick();
      if (bus2.busy_n === 1'b0) n++;
      if (fd2 === 1'b1 && f < 0) f = k;
      if (glitch && (k == 8 || k == 9)) {bus2.cs_n, bus2.rd_n} = {2{k == 8}};
    end
    if (k == 200) begin
      failures++;
      final_report();
    end
    bus2.cs_n = 1'b1;
    bus2.rd_n = 1'b1;
    bus2.hold = 1'b0;
    tick();
  endtask : conv2

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  initial begin
    reset = 1'b1;
    {req, mode, wide, wait_fresh} = 4'h0;
    code = 12'h000;
    failures = 0;
    total_checks = 0;
    {bus2.cs_n, bus2.rd_n, bus2.hold} = 3'b110;
    repeat (5) @(posedge clk_sys);
    #1 reset = 1'b0;
    tick();
    chk_word("rdata after reset", RESULT_RST, rdata);
    chk_word("result after reset", RESULT_RST, bus.result_bits);
    xfer(ADHR_SLOW, 1'b1, 1'b0, 12'h5A3);
    chk_word("slow word", 12'h5A3, rdata);
    chk_cnt("slow irq", 1, irq_seen);
    xfer(ADHR_SLOW, 1'b0, 1'b0, 12'hA5C);
    chk_word("slow bytes", 12'hA5C, rdata);
    chk_cnt("bytes irq", 1, irq_seen);
    xfer(ADHR_ROM, 1'b1, 1'b0, 12'h3C7);
    chk_word("rom word stale", 12'hA5C, rdata);
    xfer(ADHR_ROM, 1'b0, 1'b0, 12'hC38);
    chk_word("rom bytes stale", 12'h3C7, rdata);
    xfer(ADHR_ROM, 1'b0, 1'b1, 12'hF01);
    chk_word("rom fresh", 12'hF01, rdata);
    code = 12'h6E4;
    conv2(1'b0, n1, f1);
    chk_word("clean result", 12'h6E4, bus2.result_bits);
    chk_cnt("first decision", 1, int'(f1 >= DIV && f1 <= 2 * DIV + 2));
    // a run straight after another starts on the same conversion clock phase, so lengths compare
    conv2(1'b0, n1, f1);
    chk_cnt("second decision", 1, int'(f1 >= DIV && f1 <= 2 * DIV + 2));
    code = 12'h2B9;
    conv2(1'b1, n2, f2);
    chk_cnt("restart ignored", n1, n2);
    chk_word("restart result", 12'h2B9, bus2.result_bits);
    final_report();
  end
endmodule : testbench
